// File: logic/txw_defines.vh
// Shared constants for the transmit waveform template register bank
`ifndef TXW_DEFINES_VH
`define TXW_DEFINES_VH

`define TXW_NUM_CH 22
`define TXW_ADDR_W 11
`define TXW_CH_W 5
`define TXW_IDX_W 5
`define TXW_SAMPLE_W 7
`define TXW_RAM_ADDR_W 10

`define TXW_CH0_BLOCK 5'h1F
`define TXW_LAST_BLOCK 5'h14

`define TXW_OFS_PULSE 6'h06
`define TXW_OFS_GAIN 6'h07
`define TXW_OFS_CTRL 6'h08
`define TXW_OFS_DATA 6'h09

`define TXW_RST_PULSE 4'h2
`define TXW_RST_GAIN 6'h36
`define TXW_RST_CTRL 7'h00
`define TXW_RST_DATA 7'h00
`define TXW_RST_PCT 8'hA3

`define TXW_PULSE_USER_BIT 3
`define TXW_CTRL_EN_BIT 6
`define TXW_CTRL_DIR_BIT 5

`define TXW_IDX_TOP 5'h12
`define TXW_IDX_LAST 5'h13

`define TXW_GAIN_NOMINAL 6'h21
`define TXW_STEP_PCT 8'h03
`define TXW_NOMINAL_PCT 8'h64
`define TXW_SPAN_PCT 8'h64
`define TXW_MAX_PCT 8'hC8

`endif

// File: logic/txw_template_ram.v
// Waveform template sample memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module txw_template_ram #(
  parameter DATA_W = 7,
  parameter ADDR_W = 10
) (
  // Clock
  input wire i_ref_clk,
  input wire i_clk_en,
  // Access port
  input wire i_we,
  input wire i_re,
  input wire [ADDR_W-1:0] i_addr,
  input wire [DATA_W-1:0] i_wdata,
  output reg [DATA_W-1:0] o_rdata
);
  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset: sample contents are data, not control state
  always @(posedge i_ref_clk) begin
    if (i_clk_en) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      if (i_re) begin
        o_rdata <= mem[i_addr];
      end
    end
  end
endmodule // txw_template_ram
`default_nettype wire

// File: logic/txw_gain_scale.v
// Amplitude gain code to percent-of-nominal converter
`timescale 1ns/1ns
`default_nettype none
`include "txw_defines.vh"
module txw_gain_scale (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Gain code in, scale out
  input wire [5:0] i_code,
  output reg [7:0] o_pct
);
  wire up;
  wire [5:0] diff;
  wire [7:0] delta;
  reg [7:0] next_pct;

  assign up = (i_code >= `TXW_GAIN_NOMINAL);
  assign diff = up ? (i_code - `TXW_GAIN_NOMINAL) :
                (`TXW_GAIN_NOMINAL - i_code);
  // Three percent per step from nominal
  assign delta = {2'b00, diff} * `TXW_STEP_PCT;

  always @* begin
    if (up) begin
      // Clamp to the full span
      next_pct = (delta > `TXW_SPAN_PCT) ? `TXW_MAX_PCT :
                 (`TXW_NOMINAL_PCT + delta);
    end else begin
      next_pct = (delta > `TXW_SPAN_PCT) ? 8'h00 :
                 (`TXW_NOMINAL_PCT - delta);
    end
  end

  // Reset value matches the reset gain code
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pct <= `TXW_RST_PCT;
    end else if (i_clk_en) begin
      o_pct <= next_pct;
    end
  end
endmodule // txw_gain_scale
`default_nettype wire

// File: logic/txw_channel_bank.v
// Functional notes
// - Gain code scales amplitude, 100001 is nominal
// - Each code step moves amplitude three percent
// - Scaling spans plus to minus hundred percent
// - Gain code resets to 110110
// - Template fields act only with user waveform
// - Control bit 6 enables template RAM transfers
// - Control bit 5: 0 writes, 1 reads
// - Index 0-18 direct, 19 and above map 19
// - Sample value field is bits 6 to 0
// - Sample value holds until written or loaded by a RAM fetch
// - Twenty-two channel copies, 1 to 21 at fixed stride, 0 apart
// - Pulse select top bit picks user waveform
`timescale 1ns/1ns
`default_nettype none
`include "txw_defines.vh"
module txw_channel_bank #(
  parameter NUM_CH = `TXW_NUM_CH
) (
  // Clock, reset, enable
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Register port
  input wire [`TXW_ADDR_W-1:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr_stb,
  input wire i_rd_stb,
  output reg [7:0] o_rd_data,
  // Per-channel transmit controls
  output wire [NUM_CH*8-1:0] o_amp_pct,
  output wire [NUM_CH-1:0] o_user_wave
);
  wire [4:0] blk;
  wire [5:0] ofs;
  wire ch_hit;
  wire [4:0] ch;
  wire [NUM_CH*4-1:0] puls_bus;
  wire [NUM_CH*6-1:0] gain_bus;
  wire [NUM_CH*7-1:0] ctl_bus;
  wire [NUM_CH*7-1:0] dat_bus;
  wire [3:0] sel_puls;
  wire [5:0] sel_gain;
  wire [6:0] sel_ctl;
  wire [6:0] sel_dat;
  wire wr_ctl;
  wire wr_dat;
  wire user_sel;
  wire ctl_xfer;
  wire dat_xfer;
  wire ram_we;
  wire ram_re;
  wire [4:0] ram_idx;
  wire [6:0] ram_wdata;
  wire [6:0] ram_rdata;
  reg back_pend;
  reg [4:0] back_ch;
  reg [7:0] next_rd;

  function [4:0] map_idx;
    input [4:0] idx;
    begin
      map_idx = (idx > `TXW_IDX_TOP) ? `TXW_IDX_LAST : idx;
    end
  endfunction

  // Channel 0 sits apart; 1 to 21 one block each
  assign blk = i_addr[10:6];
  assign ofs = i_addr[5:0];
  assign ch_hit = (blk == `TXW_CH0_BLOCK) || (blk <= `TXW_LAST_BLOCK);
  assign ch = (blk == `TXW_CH0_BLOCK) ? 5'h00 :
              (ch_hit ? (blk + 5'h01) : 5'h00);

  assign sel_puls = puls_bus[ch*4 +: 4];
  assign sel_gain = gain_bus[ch*6 +: 6];
  assign sel_ctl = ctl_bus[ch*7 +: 7];
  assign sel_dat = dat_bus[ch*7 +: 7];

  assign wr_ctl = i_wr_stb && ch_hit && (ofs == `TXW_OFS_CTRL);
  assign wr_dat = i_wr_stb && ch_hit && (ofs == `TXW_OFS_DATA);

  // Template access only with the user waveform
  assign user_sel = sel_puls[`TXW_PULSE_USER_BIT];

  // Control write starts a transfer with its new fields
  assign ctl_xfer = wr_ctl && user_sel && i_wr_data[`TXW_CTRL_EN_BIT];
  // Data write while enabled for writing stores at once
  assign dat_xfer = wr_dat && user_sel && sel_ctl[`TXW_CTRL_EN_BIT] &&
                    !sel_ctl[`TXW_CTRL_DIR_BIT];

  // Direction bit: 0 stores, 1 fetches
  assign ram_we = (ctl_xfer && !i_wr_data[`TXW_CTRL_DIR_BIT]) || dat_xfer;
  assign ram_re = ctl_xfer && i_wr_data[`TXW_CTRL_DIR_BIT];
  // Out-of-range index folds onto the last sample
  assign ram_idx = wr_ctl ? map_idx(i_wr_data[4:0]) : map_idx(sel_ctl[4:0]);
  assign ram_wdata = wr_dat ? i_wr_data[6:0] : sel_dat;

  txw_template_ram #(
    .DATA_W(`TXW_SAMPLE_W),
    .ADDR_W(`TXW_RAM_ADDR_W)
  ) u_ram (
    .i_ref_clk(i_ref_clk),
    .i_clk_en(i_clk_en),
    .i_we(ram_we),
    .i_re(ram_re),
    .i_addr({ch, ram_idx}),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  // Read result lands one cycle after the RAM fetch
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      back_pend <= 1'b0;
      back_ch <= 5'h00;
    end else if (i_clk_en) begin
      back_pend <= ram_re;
      back_ch <= ch;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      localparam [4:0] CH_ID = g;
      wire sel;
      reg [3:0] puls;
      reg [5:0] gain;
      reg [6:0] ctl;
      reg [6:0] dat;

      assign sel = ch_hit && (ch == CH_ID);

      always @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          puls <= `TXW_RST_PULSE;
          gain <= `TXW_RST_GAIN;
          ctl <= `TXW_RST_CTRL;
          dat <= `TXW_RST_DATA;
        end else if (i_clk_en) begin
          if (i_wr_stb && sel && (ofs == `TXW_OFS_PULSE)) begin
            puls <= i_wr_data[3:0];
          end
          if (i_wr_stb && sel && (ofs == `TXW_OFS_GAIN)) begin
            gain <= i_wr_data[5:0];
          end
          if (wr_ctl && sel) begin
            ctl <= i_wr_data[6:0];
          end
          // Software write beats a same-cycle readback
          if (wr_dat && sel) begin
            dat <= i_wr_data[6:0];
          end else if (back_pend && (back_ch == CH_ID)) begin
            dat <= ram_rdata;
          end
        end
      end

      assign puls_bus[g*4 +: 4] = puls;
      assign gain_bus[g*6 +: 6] = gain;
      assign ctl_bus[g*7 +: 7] = ctl;
      assign dat_bus[g*7 +: 7] = dat;
      assign o_user_wave[g] = puls[`TXW_PULSE_USER_BIT];

      txw_gain_scale u_scale (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_code(gain),
        .o_pct(o_amp_pct[g*8 +: 8])
      );
    end
  endgenerate

  // Reserved bits and unmapped addresses read zero
  always @* begin
    next_rd = 8'h00;
    if (ch_hit) begin
      case (ofs)
        `TXW_OFS_PULSE: next_rd = {4'h0, sel_puls};
        `TXW_OFS_GAIN: next_rd = {2'h0, sel_gain};
        `TXW_OFS_CTRL: next_rd = {1'b0, sel_ctl};
        `TXW_OFS_DATA: next_rd = {1'b0, sel_dat};
        default: next_rd = 8'h00;
      endcase
    end
  end

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
    end else if (i_clk_en) begin
      o_rd_data <= i_rd_stb ? next_rd : 8'h00;
    end
  end
endmodule // txw_channel_bank
`default_nettype wire

// File: verification/txw_bank_chk.sv
// Assertion checker for the waveform template register bank
`timescale 1ns/1ns
`default_nettype none
module txw_bank_chk #(parameter NUM_CH = 22) (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Register port
  input wire [10:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire i_wr_stb,
  input wire i_rd_stb,
  input wire [7:0] o_rd_data,
  // Channel controls
  input wire [NUM_CH*8-1:0] o_amp_pct,
  input wire [NUM_CH-1:0] o_user_wave
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Scale lands two edges after the gain write
  property p_gain(a, int n);
    i_wr_stb && i_clk_en && i_addr == a ##1 i_clk_en [*2] |->
      o_amp_pct[n*8+:8] == 3 * $past(i_wr_data[5:0], 2) + 1;
  endproperty
  AST_RST: assert property (disable iff (1'b0)
    !i_reset_n |-> o_amp_pct[7:0] == 8'hA3 && o_user_wave == '0)
    else $error("Reset outputs wrong");
  AST_NOM: assert property (i_wr_stb && i_clk_en &&
    i_addr == 11'h047 && i_wr_data[5:0] == 6'h21 ##1 i_clk_en [*2]
    |-> o_amp_pct[23:16] == 8'h64) else $error("Nominal scale wrong");
  AST_GAIN1: assert property (p_gain(11'h007, 1))
    else $error("Channel 1 scale wrong");
  AST_GAIN0: assert property (p_gain(11'h7C7, 0))
    else $error("Channel 0 scale wrong");
  AST_GAIN21: assert property (p_gain(11'h507, 21))
    else $error("Channel 21 scale wrong");
  AST_PCT_MAX: assert property (o_amp_pct[15:8] <= 8'hC8)
    else $error("Scale above span");
  AST_RD_B7: assert property (o_rd_data[7] == 1'b0)
    else $error("Reserved bit set");
  AST_RD_IDLE: assert property ($past(i_clk_en) &&
    !$past(i_rd_stb) |-> o_rd_data == 8'h00) else $error("Stray data");
  AST_UNMAP: assert property (i_rd_stb && i_clk_en &&
    i_addr >= 11'h540 && i_addr < 11'h7C0 |=> o_rd_data == 8'h00)
    else $error("Unmapped read nonzero");
  cover property (i_wr_stb && i_addr == 11'h007);
  cover property (i_rd_stb && i_addr == 11'h089);
  cover property (i_rd_stb && i_addr == 11'h540);
endmodule // txw_bank_chk
bind txw_channel_bank txw_bank_chk #(.NUM_CH(NUM_CH)) i_chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb),
  .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data), .o_amp_pct(o_amp_pct),
  .o_user_wave(o_user_wave));
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the waveform template register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b1;
  logic i_clk_en = 1'b1;
  logic [10:0] i_addr = 11'h000;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic [7:0] o_rd_data;
  logic [175:0] o_amp_pct;
  logic [21:0] o_user_wave;
  logic [6:0] mem [20];
  int mismatches = 0;
  int checked = 0;
  int cc [4] = '{1, 0, 21, 2};
  int cv [4] = '{0, 63, 33, 33};
  txw_channel_bank i_dut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .o_amp_pct(o_amp_pct), .o_user_wave(o_user_wave));
  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [10:0] base(int ch);
    return ch == 0 ? 11'h7C0 : 11'((ch - 1) * 64);
  endfunction
  // Percent of nominal: 3 per step around code 33, clamped
  function automatic logic [7:0] pct(int c);
    int p;
    p = 100 + 3 * (c - 33);
    return 8'(p < 0 ? 0 : (p > 200 ? 200 : p));
  endfunction
  task automatic wr(logic [10:0] a, logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= v;
    i_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_stb <= 1'b0;
  endtask
  task automatic chk(logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rchk(logic [10:0] a, logic [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_stb <= 1'b0;
    #1 chk(e, o_rd_data);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end
  initial begin
    int ch, c, i;
    void'($urandom(56));
    // Falling edge gives the asynchronous reset an event at start
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    for (ch = 0; ch < 22; ch++) begin
      rchk(base(ch) + 11'h006, 8'h02);
      rchk(base(ch) + 11'h007, 8'h36);
      rchk(base(ch) + 11'h008, 8'h00);
      rchk(base(ch) + 11'h009, 8'h00);
      chk(8'hA3, o_amp_pct[ch*8+:8]);
    end
    wr(11'h540, 8'h11);
    rchk(11'h540, 8'h00);
    rchk(11'h00A, 8'h00);
    // Frozen enable must swallow a write strobe
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    wr(base(5) + 11'h007, 8'h21);
    i_clk_en <= 1'b1;
    rchk(base(5) + 11'h007, 8'h36);
    chk(8'hA3, o_amp_pct[47:40]);
    // Corner codes first, reserved top bits set at random
    for (i = 0; i < 28; i++) begin
      ch = i < 4 ? cc[i] : $urandom % 22;
      c = i < 4 ? cv[i] : $urandom % 64;
      wr(base(ch) + 11'h007, 8'($urandom) & 8'hC0 | 8'(c));
      @(posedge i_ref_clk);
      #1 chk(pct(c), o_amp_pct[ch*8+:8]);
      rchk(base(ch) + 11'h007, 8'(c));
    end
    wr(11'h086, 8'h08);
    @(posedge i_ref_clk);
    #1 chk(8'h01, {7'h00, o_user_wave[3]});
    // Disable first so the data write cannot store at the old index
    for (i = 0; i < 20; i++) begin
      mem[i] = 7'($urandom);
      wr(11'h088, 8'(i));
      wr(11'h089, {1'b1, mem[i]});
      wr(11'h088, 8'h40 | 8'(i));
    end
    mem[19] = 7'($urandom);
    wr(11'h088, 8'h1F);
    wr(11'h089, {1'b0, mem[19]});
    wr(11'h088, 8'h5F);
    wr(11'h086, 8'h02);
    wr(11'h088, 8'h05);
    wr(11'h089, {1'b0, ~mem[5]});
    wr(11'h088, 8'h45);
    wr(11'h086, 8'h0F);
    rchk(11'h089, {1'b0, ~mem[5]});
    for (i = 0; i < 20; i++) begin
      wr(11'h088, 8'h60 | 8'(i));
      rchk(11'h089, {1'b0, mem[i]});
    end
    rchk(11'h088, 8'h73);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
